// ---- rtl/scr_defs.svh ----
// Purpose: Constants for the synthesizer control register bank
// Assumes: Included by scr_pkg and scr_core
// Notes: Bit positions refer to the 20-bit data field of a frame
`ifndef SCR_DEFS_SVH
`define SCR_DEFS_SVH

// ****************************************
// Frame layout
// ****************************************
`define SCR_DATA_W 20
`define SCR_ADDR_W 4
`define SCR_FRAME_W 24

// ****************************************
// Register addresses
// ****************************************
`define SCR_ADDR_FRACTION 4'h1
`define SCR_ADDR_WHOLE 4'h2
`define SCR_ADDR_RATIO 4'h3
`define SCR_ADDR_QUICK 4'h4

// ****************************************
// Field positions
// ****************************************
`define SCR_FRAC_MSB 17
`define SCR_PUMP_MSB 18
`define SCR_PUMP_LSB 15
`define SCR_WHOLE_MSB 14
`define SCR_FLOAT_BIT 15
`define SCR_SPREAD_BIT 14
`define SCR_WIN_MSB 13
`define SCR_WIN_LSB 12
`define SCR_SRC_BIT 11
`define SCR_POL_BIT 10
`define SCR_PRE_MSB 9
`define SCR_PRE_LSB 8
`define SCR_REFDIV_MSB 7
`define SCR_QEN_BIT 16
`define SCR_BOOST_MSB 15
`define SCR_BOOST_LSB 13
`define SCR_QCNT_MSB 12

// ****************************************
// Reset values and timing counts
// ****************************************
`define SCR_RESET_WORD 20'h00000
`define SCR_LOCK_COUNT 6'h3F
`define SCR_UNLOCK_COUNT 6'h08

`endif

// ---- rtl/scr_pkg.sv ----
// Purpose: Types for the synthesizer control register bank
// Assumes: scr_defs.svh holds the field positions; the widths here are written out
// Notes: Settings leave the block as one packed struct
`include "scr_defs.svh"

package scr_pkg;

	// ****************************************
	// Settings carried to the analog side
	// ****************************************
	typedef struct packed {
		logic [17:0] fraction;
		logic [14:0] whole_divide;
		logic [3:0] normal_pump_current;
		logic pump_output_float;
		logic modulator_noise_spread;
		logic [1:0] lock_window_select;
		logic lock_indicator_source;
		logic pump_polarity;
		logic prescaler_16;
		logic [7:0] ref_divide;
		logic quick_lock_enable;
		logic [2:0] boost_pump_current;
		logic [12:0] quick_lock_count;
	} scr_cfg_s;

	typedef enum logic [0:0] {
		SCR_QL_IDLE = 1'b0,
		SCR_QL_BOOST = 1'b1
	} scr_ql_state_e;

endpackage : scr_pkg

// ---- rtl/scr_core.sv ----
// Purpose: Serial-loaded control registers of a fractional-N synthesizer
// Assumes: All pins are asynchronous to ref_clk and slow against it
// Notes: Frame is 20 data bits then 4 address bits, MSB first
//
// How it works
// - Numerator waits in a pending copy until the integer word is written.
// - Contents are meaningless until the host writes all four addresses.
// - Address 1 low eighteen bits are a two's complement numerator.
// - Address 2 holds pump current code D18..D15 and integer D14..D0.
// - Address 3 bit 15 floats both pump outputs when set.
// - Address 3 bit 14 turns modulator dithering on when set.
// - Address 3 bit 11 picks analog phase result over digital lock detect.
// - Address 3 bit 10 makes both pumps negative polarity when set.
// - Prescaler field codes 0 and 1 mean eight, 2 and 3 mean sixteen.
// - Address 4 bit 16 enables quick lock switchover.
// - Address 4 holds boost current D15..D13 and duration count D12..D0.
// - Frequency changes on the strobe rise ending a numerator or integer write.
// - Quick lock closes switch and boosts pump for the programmed phase cycles.
// - Digital lock drops at each frequency load, rises after 63 good comparisons.
`timescale 1ns/10ps
`include "scr_defs.svh"

module scr_core
	import scr_pkg::*;
#(
	parameter logic [5:0] UNLOCK_ERRS = `SCR_UNLOCK_COUNT
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic serial_clk,
	input wire logic serial_data,
	input wire logic latch_strobe,
	input wire logic standby_control_pin,
	input wire logic pfd_tick,
	input wire logic phase_err_small,
	input wire logic pfd_analog,
	output scr_cfg_s cfg,
	output logic freq_change,
	output logic loop_switch_closed,
	output logic boost_pump_active,
	output logic lock_out
);

	// ****************************************
	// Pin conditioning
	// ****************************************
	localparam int NPIN = 7;
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] pin_s1_r;
	logic [NPIN-1:0] pin_s2_r;
	logic [NPIN-1:0] pin_s3_r;
	logic [NPIN-1:0] pin_r;
	logic [NPIN-1:0] pin_nxt;
	logic [NPIN-1:0] pin_prev_r;
	logic [NPIN-1:0] pin_rise;

	assign pin_raw = {pfd_analog, phase_err_small, pfd_tick, standby_control_pin, latch_strobe, serial_data, serial_clk};
	// A change counts only once the second and third stages agree
	assign pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
	assign pin_rise = pin_r & ~pin_prev_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			pin_s1_r <= '0;
			pin_s2_r <= '0;
			pin_s3_r <= '0;
			pin_r <= '0;
			pin_prev_r <= '0;
		end else begin
			pin_s1_r <= pin_raw;
			pin_s2_r <= pin_s1_r;
			pin_s3_r <= pin_s2_r;
			pin_r <= pin_nxt;
			pin_prev_r <= pin_r;
		end
	end

	wire sclk_rise = pin_rise[0];
	wire sdata = pin_r[1];
	wire strobe_rise = pin_rise[2];
	wire standby_rise = pin_rise[3];
	wire tick_rise = pin_rise[4];
	wire err_small = pin_r[5];
	wire analog_lvl = pin_r[6];

	// ****************************************
	// Shift register and address decode
	// ****************************************
	logic [`SCR_FRAME_W-1:0] shift_r;
	logic [`SCR_FRAME_W-1:0] shift_nxt;

	assign shift_nxt = sclk_rise ? {shift_r[`SCR_FRAME_W-2:0], sdata} : shift_r;

	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			shift_r <= '0;
		end else begin
			shift_r <= shift_nxt;
		end
	end

	function automatic logic addr_is(input logic [`SCR_ADDR_W-1:0] got, input logic [`SCR_ADDR_W-1:0] want);
		return got == want;
	endfunction : addr_is

	wire [`SCR_ADDR_W-1:0] frame_addr = shift_r[`SCR_ADDR_W-1:0];
	wire [`SCR_DATA_W-1:0] d = shift_r[`SCR_FRAME_W-1:`SCR_ADDR_W];
	wire wr_frac = strobe_rise && addr_is(frame_addr, `SCR_ADDR_FRACTION);
	wire wr_whole = strobe_rise && addr_is(frame_addr, `SCR_ADDR_WHOLE);
	wire wr_ratio = strobe_rise && addr_is(frame_addr, `SCR_ADDR_RATIO);
	wire wr_quick = strobe_rise && addr_is(frame_addr, `SCR_ADDR_QUICK);
	wire freq_load = wr_frac | wr_whole;

	// ****************************************
	// Register storage
	// ****************************************
	logic [17:0] frac_pend_r;
	scr_cfg_s cfg_r;
	scr_cfg_s cfg_nxt;

	always_comb begin
		cfg_nxt = cfg_r;
		if (wr_whole) begin
			cfg_nxt.fraction = frac_pend_r;
			cfg_nxt.normal_pump_current = d[`SCR_PUMP_MSB:`SCR_PUMP_LSB];
			cfg_nxt.whole_divide = d[`SCR_WHOLE_MSB:0];
		end
		if (wr_ratio) begin
			cfg_nxt.pump_output_float = d[`SCR_FLOAT_BIT];
			cfg_nxt.modulator_noise_spread = d[`SCR_SPREAD_BIT];
			cfg_nxt.lock_window_select = d[`SCR_WIN_MSB:`SCR_WIN_LSB];
			cfg_nxt.lock_indicator_source = d[`SCR_SRC_BIT];
			cfg_nxt.pump_polarity = d[`SCR_POL_BIT];
			cfg_nxt.prescaler_16 = d[`SCR_PRE_MSB];
			cfg_nxt.ref_divide = d[`SCR_REFDIV_MSB:0];
		end
		if (wr_quick) begin
			cfg_nxt.quick_lock_enable = d[`SCR_QEN_BIT];
			cfg_nxt.boost_pump_current = d[`SCR_BOOST_MSB:`SCR_BOOST_LSB];
			cfg_nxt.quick_lock_count = d[`SCR_QCNT_MSB:0];
		end
	end

	// Reset gives zeros only for determinism; software must still load all words
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			frac_pend_r <= '0;
			cfg_r <= '0;
		end else begin
			if (wr_frac) begin
				frac_pend_r <= d[`SCR_FRAC_MSB:0];
			end
			cfg_r <= cfg_nxt;
		end
	end

	// ****************************************
	// Quick lock timer
	// ****************************************
	scr_ql_state_e ql_state_r;
	scr_ql_state_e ql_state_nxt;
	logic [12:0] ql_cnt_r;
	logic [12:0] ql_cnt_nxt;
	wire ql_start = cfg_r.quick_lock_enable && (freq_load || standby_rise);

	always_comb begin
		ql_state_nxt = ql_state_r;
		ql_cnt_nxt = ql_cnt_r;
		case (ql_state_r)
			SCR_QL_IDLE: begin
				if (ql_start) begin
					ql_state_nxt = SCR_QL_BOOST;
					ql_cnt_nxt = cfg_r.quick_lock_count;
				end
			end
			SCR_QL_BOOST: begin
				// A restart inside the window reloads the full count
				if (ql_start) begin
					ql_cnt_nxt = cfg_r.quick_lock_count;
				end else if (tick_rise) begin
					ql_cnt_nxt = ql_cnt_r - 13'h0001;
					if (ql_cnt_r <= 13'h0001) begin
						ql_state_nxt = SCR_QL_IDLE;
					end
				end
			end
			default: begin
				ql_state_nxt = SCR_QL_IDLE;
			end
		endcase
	end

	// ****************************************
	// Lock detect
	// ****************************************
	logic [5:0] good_cnt_r;
	logic [5:0] good_cnt_nxt;
	logic [5:0] bad_cnt_r;
	logic [5:0] bad_cnt_nxt;
	logic dig_lock_r;
	logic dig_lock_nxt;

	always_comb begin
		good_cnt_nxt = good_cnt_r;
		bad_cnt_nxt = bad_cnt_r;
		dig_lock_nxt = dig_lock_r;
		if (freq_load) begin
			good_cnt_nxt = '0;
			bad_cnt_nxt = '0;
			dig_lock_nxt = 1'b0;
		end else if (tick_rise) begin
			if (err_small) begin
				bad_cnt_nxt = '0;
				if (good_cnt_r != `SCR_LOCK_COUNT) begin
					good_cnt_nxt = good_cnt_r + 6'h01;
				end
				if (good_cnt_r >= `SCR_LOCK_COUNT - 6'h01) begin
					dig_lock_nxt = 1'b1;
				end
			end else begin
				good_cnt_nxt = '0;
				if (bad_cnt_r != UNLOCK_ERRS) begin
					bad_cnt_nxt = bad_cnt_r + 6'h01;
				end
				if (bad_cnt_r >= UNLOCK_ERRS - 6'h01) begin
					dig_lock_nxt = 1'b0;
				end
			end
		end
	end

	// ****************************************
	// State and output registers
	// ****************************************
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ql_state_r <= SCR_QL_IDLE;
			ql_cnt_r <= '0;
			good_cnt_r <= '0;
			bad_cnt_r <= '0;
			dig_lock_r <= 1'b0;
			freq_change <= 1'b0;
			loop_switch_closed <= 1'b0;
			boost_pump_active <= 1'b0;
			lock_out <= 1'b0;
			cfg <= '0;
		end else begin
			ql_state_r <= ql_state_nxt;
			ql_cnt_r <= ql_cnt_nxt;
			good_cnt_r <= good_cnt_nxt;
			bad_cnt_r <= bad_cnt_nxt;
			dig_lock_r <= dig_lock_nxt;
			freq_change <= freq_load;
			loop_switch_closed <= (ql_state_nxt == SCR_QL_BOOST);
			boost_pump_active <= (ql_state_nxt == SCR_QL_BOOST);
			lock_out <= cfg_r.lock_indicator_source ? analog_lvl : dig_lock_nxt;
			cfg <= cfg_nxt;
		end
	end

endmodule : scr_core

// ---- tb/scr_core_assertions.sv ----
// Purpose: Port checks on scr_core
// Assumes: Bound from the bench top
// Notes: Pin filter delay fits inside the 8-cycle windows
`timescale 1ns/10ps
module scr_chk
	import scr_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic pfd_tick,
	input wire logic pfd_analog,
	input wire scr_cfg_s cfg,
	input wire logic freq_change,
	input wire logic loop_switch_closed,
	input wire logic boost_pump_active,
	input wire logic lock_out
);
	// ****************
	// Properties
	// ****************
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	sequence s_ana(v);
		(cfg.lock_indicator_source && pfd_analog == v) [*8];
	endsequence
	sequence s_calm;
		(loop_switch_closed && !pfd_tick) [*8];
	endsequence
	property p_pulse; freq_change |=> !freq_change; endproperty
	a_pulse: assert property (p_pulse) else $error("freq_change too wide");
	property p_frac; $changed(cfg.fraction) |-> freq_change; endproperty
	a_frac: assert property (p_frac) else $error("fraction moved alone");
	property p_ratio; $changed(cfg.ref_divide) |-> !freq_change; endproperty
	a_ratio: assert property (p_ratio) else $error("ratio word hit freq");
	property p_twin; loop_switch_closed == boost_pump_active; endproperty
	a_twin: assert property (p_twin) else $error("switch and boost differ");
	// Pin filter puts the tick rise five samples before the window closes
	property p_end; $fell(loop_switch_closed) |-> $past(pfd_tick, 4) && $past(pfd_tick, 5); endproperty
	a_end: assert property (p_end) else $error("quick lock ended without tick");
	property p_start; freq_change && cfg.quick_lock_enable |-> loop_switch_closed; endproperty
	a_start: assert property (p_start) else $error("quick lock not started");
	property p_hold; s_calm |=> loop_switch_closed; endproperty
	a_hold: assert property (p_hold) else $error("quick lock ended idle");
	property p_ana_hi; s_ana(1'b1) |-> lock_out; endproperty
	a_ana_hi: assert property (p_ana_hi) else $error("analog high lost");
	property p_ana_lo; s_ana(1'b0) |-> !lock_out; endproperty
	a_ana_lo: assert property (p_ana_lo) else $error("analog low lost");
	property p_dig; freq_change && !cfg.lock_indicator_source |-> !lock_out; endproperty
	a_dig: assert property (p_dig) else $error("lock kept over load");
endmodule : scr_chk

// ---- tb/scr_host.sv ----
// Purpose: Host side of the three-line load link
// Assumes: Called just after a falling ref_clk edge
// Notes: HOLD sets link speed; clock idles low between frames
`timescale 1ns/10ps
module scr_host #(
	parameter int HOLD = 5
) (
	input wire logic ref_clk,
	output logic serial_clk,
	output logic serial_data,
	output logic latch_strobe
);
	initial begin
		serial_clk = 1'b0;
		serial_data = 1'b0;
		latch_strobe = 1'b0;
	end
	task automatic send(input logic [3:0] a, input logic [19:0] d);
		logic [23:0] f;
		f = {d, a};
		for (int i = 23; i >= 0; i--) begin
			serial_data = f[i];
			repeat (HOLD) @(negedge ref_clk);
			serial_clk = 1'b1;
			repeat (HOLD) @(negedge ref_clk);
			serial_clk = 1'b0;
		end
		// Released line must not show a stale bit
		serial_data = ~serial_data;
		latch_strobe = 1'b1;
		repeat (HOLD) @(negedge ref_clk);
		latch_strobe = 1'b0;
		repeat (HOLD) @(negedge ref_clk);
	endtask : send
endmodule : scr_host

// ---- tb/synth_control_registers_tb.sv ----
// Purpose: Self-checking bench for scr_core
// Assumes: Host model drives the load link
// Notes: Seeded random words plus fixed corner values
`timescale 1ns/10ps
module synth_control_registers_tb
	import scr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic standby_control_pin = 1'b0;
	logic pfd_tick = 1'b0;
	logic phase_err_small = 1'b1;
	logic pfd_analog = 1'b0;
	logic serial_clk, serial_data, latch_strobe, freq_change, loop_switch_closed, boost_pump_active, lock_out;
	scr_cfg_s cfg;
	logic [19:0] w2 = 20'h00000, w3 = 20'h00000, w4 = 20'h00000;
	logic [17:0] pend = 18'h00000, frac = 18'h00000;
	int seed = 58;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	int n;
	int pulses = 0;
	initial forever #12.5 ref_clk = ~ref_clk;
	scr_host #(.HOLD(5)) host (.ref_clk(ref_clk), .serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe));
	scr_core dut (.ref_clk(ref_clk), .rstn(rstn), .serial_clk(serial_clk), .serial_data(serial_data),
		.latch_strobe(latch_strobe), .standby_control_pin(standby_control_pin), .pfd_tick(pfd_tick),
		.phase_err_small(phase_err_small), .pfd_analog(pfd_analog), .cfg(cfg), .freq_change(freq_change),
		.loop_switch_closed(loop_switch_closed), .boost_pump_active(boost_pump_active), .lock_out(lock_out));
	// ****************
	// Helpers
	// ****************
	function automatic scr_cfg_s model();
		return {frac, w2[14:0], w2[18:15], w3[15], w3[14], w3[13:12], w3[11], w3[10], w3[9], w3[7:0], w4[16],
			w4[15:13], w4[12:0]};
	endfunction : model
	function automatic logic [19:0] cfg3(input logic src, input logic [1:0] pre, input logic [7:0] r);
		return {4'h0, 2'($random(seed)), 2'b00, src, 1'($random(seed)), pre, r};
	endfunction : cfg3
	task automatic chk_cfg(input scr_cfg_s e);
		comparisons++;
		if (cfg !== e) begin
			error_cnt++;
			$display("[ERR] cfg exp %h got %h", e, cfg);
		end
	endtask : chk_cfg
	task automatic chk_bit(input string what, input logic e, input logic g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[ERR] %s exp %b got %b", what, e, g);
		end
	endtask : chk_bit
	task automatic chk_cnt(input string what, input int e, input int g);
		comparisons++;
		if (g != e) begin
			error_cnt++;
			$display("[ERR] %s exp %0d got %0d", what, e, g);
		end
	endtask : chk_cnt
	task automatic wr(input logic [3:0] a, input logic [19:0] d);
		host.send(a, d);
		if (a == 4'h1) pend = d[17:0];
		if (a == 4'h2) frac = pend;
		if (a == 4'h2) w2 = d;
		if (a == 4'h3) w3 = d;
		if (a == 4'h4) w4 = d;
		repeat (4) @(negedge ref_clk);
		chk_cfg(model());
	endtask : wr
	task automatic tick(input int k);
		repeat (k) begin
			pfd_tick = 1'b1;
			repeat (5) @(negedge ref_clk);
			pfd_tick = 1'b0;
			repeat (5) @(negedge ref_clk);
		end
	endtask : tick
	task automatic complete_run();
		if (error_cnt == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : complete_run
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 30000) begin
			error_cnt++;
			$display("[ERR] run exp done got hang");
			complete_run();
		end
	end
	// Counted mid-cycle so the one-cycle pulse is settled
	always @(negedge ref_clk) begin
		if (freq_change === 1'b1) pulses++;
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		repeat (16) @(negedge ref_clk);
		rstn = 1'b1;
		@(negedge ref_clk);
		for (int i = 0; i < 4; i++) wr(4'h3, cfg3(1'b0, i[1:0], (i == 0) ? 8'h04 : 8'hFF));
		n = 2 + $unsigned($random(seed)) % 4;
		wr(4'h4, {3'h0, 1'b1, 3'($random(seed)), 13'(n)});
		wr(4'h1, 20'($random(seed)) & 20'h3FFFF);
		wr(4'h2, 20'($random(seed)) & 20'h7FFFF);
		chk_bit("switch", 1'b1, loop_switch_closed);
		tick(n - 1);
		chk_bit("boost", 1'b1, boost_pump_active);
		tick(1);
		chk_bit("switch", 1'b0, loop_switch_closed);
		wr(4'h0, 20'hFFFFF);
		wr(4'h5, 20'hFFFFF);
		standby_control_pin = 1'b1;
		repeat (16) @(negedge ref_clk);
		chk_bit("standby", 1'b1, loop_switch_closed);
		wr(4'h1, 20'h00001);
		// One bad comparison must restart the run of 63
		tick(n * 10);
		phase_err_small = 1'b0;
		tick(1);
		phase_err_small = 1'b1;
		tick(62);
		chk_bit("lock", 1'b0, lock_out);
		tick(1);
		chk_bit("lock", 1'b1, lock_out);
		wr(4'h3, cfg3(1'b1, 2'b10, 8'hFF));
		pfd_analog = 1'b1;
		repeat (10) @(negedge ref_clk);
		chk_bit("analog", 1'b1, lock_out);
		pfd_analog = 1'b0;
		repeat (10) @(negedge ref_clk);
		chk_bit("analog", 1'b0, lock_out);
		wr(4'h4, {3'h0, 1'b0, 3'($random(seed)), 13'(n)});
		wr(4'h2, 20'($random(seed)) & 20'h7FFFF);
		chk_bit("switch", 1'b0, loop_switch_closed);
		chk_cnt("freq pulses", 4, pulses);
		complete_run();
	end
endmodule : synth_control_registers_tb
bind scr_core scr_chk chk (.ref_clk(ref_clk), .rstn(rstn), .pfd_tick(pfd_tick), .pfd_analog(pfd_analog),
	.cfg(cfg), .freq_change(freq_change), .loop_switch_closed(loop_switch_closed),
	.boost_pump_active(boost_pump_active), .lock_out(lock_out));
